// ### scid_top.sv
// Command and control input decoder of a digital servo drive, APB registers
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/100ps
module scid_top #(
    parameter int ADC_W = 14,
    parameter logic [15:0] PEAK_CURRENT = 16'h4000
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output wire logic PREADY,
    output wire logic PSLVERR,
    input wire logic FAST_IN_ONE,
    input wire logic FAST_IN_TWO,
    input wire logic ENABLE_IN,
    input wire logic RESET_IN,
    input wire logic OVERHEAT_IN,
    input wire logic MAIN_POWER_OK,
    input wire logic FOLDBACK_ACTIVE,
    input wire logic [ADC_W-1:0] ANALOG_CMD,
    output logic MOTOR_POWER,
    output logic DRIVE_HEALTHY,
    output logic FOLDBACK,
    output wire logic LOADER_MODE,
    output wire logic [15:0] POS_COUNT,
    output wire logic [15:0] POS_REVS,
    output logic [15:0] CURRENT_CMD,
    output logic [15:0] VELOCITY_CMD
);
    // Configuration registers
    logic [6:0] ctrl_q;
    logic [15:0] ppt_q;
    logic [15:0] top_q;
    logic [15:0] rise_q;
    logic [15:0] fall_q;
    logic [15:0] dtorq_q;
    logic [15:0] dspeed_q;
    logic [31:0] prdata_q;

    // State
    scid_pkg::scid_state_t st_q;
    scid_pkg::scid_state_t st_d;
    logic one_q;
    logic two_q;
    logic ena_prev_q;
    logic rstin_prev_q;
    logic hw_en_q;
    logic hw_en_d;
    logic overheat_q;
    logic signed [15:0] vel_q;
    logic signed [15:0] vel_d;

    // APB decode
    wire setup = PSEL && !PENABLE;
    wire wr = PSEL && PENABLE && PWRITE;
    wire hit_ctrl = PADDR == scid_pkg::OFS_CTRL;
    wire hit_ppt = PADDR == scid_pkg::OFS_PPT;
    wire hit_top = PADDR == scid_pkg::OFS_TOP;
    wire hit_rise = PADDR == scid_pkg::OFS_RISE;
    wire hit_fall = PADDR == scid_pkg::OFS_FALL;
    wire hit_dtorq = PADDR == scid_pkg::OFS_DTORQ;
    wire hit_dspeed = PADDR == scid_pkg::OFS_DSPEED;
    wire hit_status = PADDR == scid_pkg::OFS_STATUS;
    wire hit_pos = PADDR == scid_pkg::OFS_POS;
    wire hit_cmdout = PADDR == scid_pkg::OFS_CMDOUT;
    wire hit_any = hit_ctrl || hit_ppt || hit_top || hit_rise || hit_fall || hit_dtorq
        || hit_dspeed || hit_status || hit_pos || hit_cmdout;
    wire hit_ro = hit_status || hit_pos || hit_cmdout;

    // Zero wait states; writes to read-only words and any access to unmapped words are flagged
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && (!hit_any || (PWRITE && hit_ro));
    assign PRDATA = prdata_q;

    // Control fields
    wire [1:0] dec_sel = ctrl_q[scid_pkg::CTRL_SEL_HI:scid_pkg::CTRL_SEL_LO];
    wire or_combine = ctrl_q[scid_pkg::CTRL_OR_COMBINE];
    wire sw_enable = ctrl_q[scid_pkg::CTRL_SW_ENABLE];
    wire thermal_watch = ctrl_q[scid_pkg::CTRL_THERMAL_WATCH];
    wire vel_mode = ctrl_q[scid_pkg::CTRL_VEL_MODE];
    wire digital_src = ctrl_q[scid_pkg::CTRL_DIGITAL_SRC];

    // Power-up loader handling
    // Power-up with the reset input high parks the block in the loader until
    // the input has gone low and then high again
    wire running = st_q == scid_pkg::SCID_ST_RUN;
    assign LOADER_MODE = (st_q == scid_pkg::SCID_ST_LDLOW) || (st_q == scid_pkg::SCID_ST_LDHIGH);

    always_comb begin
        case (st_q)
            scid_pkg::SCID_ST_BOOT: begin
                st_d = RESET_IN ? scid_pkg::SCID_ST_LDLOW : scid_pkg::SCID_ST_RUN;
            end
            scid_pkg::SCID_ST_LDLOW: begin
                st_d = RESET_IN ? scid_pkg::SCID_ST_LDLOW : scid_pkg::SCID_ST_LDHIGH;
            end
            scid_pkg::SCID_ST_LDHIGH: begin
                st_d = RESET_IN ? scid_pkg::SCID_ST_RUN : scid_pkg::SCID_ST_LDHIGH;
            end
            scid_pkg::SCID_ST_RUN: begin
                st_d = scid_pkg::SCID_ST_RUN;
            end
            default: begin
                st_d = scid_pkg::SCID_ST_BOOT;
            end
        endcase
    end

    // Enable and reset inputs
    wire ena_rise = ENABLE_IN && !ena_prev_q;
    wire rstin_fall = rstin_prev_q && !RESET_IN;
    wire fault = overheat_q;

    always_comb begin
        hw_en_d = hw_en_q;
        if (!running || !ENABLE_IN || RESET_IN || fault) begin
            // A fault drops the latch so power cannot return on a held level
            hw_en_d = 1'b0;
        end else if (rstin_fall) begin
            hw_en_d = 1'b1;
        end else if (ena_rise) begin
            hw_en_d = 1'b1;
        end
    end

    wire en_combined = or_combine ? (hw_en_q || sw_enable) : (hw_en_q && sw_enable);
    wire power_d = running && !RESET_IN && !fault && en_combined;

    // Overheat fault; a new overheat wins over a reset-input clear
    wire overheat_set = running && thermal_watch && OVERHEAT_IN;
    wire overheat_d = overheat_set || (overheat_q && !RESET_IN);

    // Fast input decoders
    wire one_rise = FAST_IN_ONE && !one_q;
    wire two_rise = FAST_IN_TWO && !two_q;
    logic [3:0] quad_tr;
    assign quad_tr = {one_q, two_q, FAST_IN_ONE, FAST_IN_TWO};
    // A leading B counts forward
    // Codes that change both bits in one cycle are not counted: the direction
    // is unknown, so a too-fast encoder loses counts rather than gaining them
    wire quad_fwd = quad_tr == 4'h2 || quad_tr == 4'hB || quad_tr == 4'hD || quad_tr == 4'h4;
    wire quad_rev = quad_tr == 4'h1 || quad_tr == 4'h7 || quad_tr == 4'hE || quad_tr == 4'h8;

    logic cnt_up;
    logic cnt_dn;

    always_comb begin
        cnt_up = 1'b0;
        cnt_dn = 1'b0;
        if (running) begin
            case (dec_sel)
                scid_pkg::SCID_DEC_STEPDIR: begin
                    // Direction level taken at the step edge itself
                    cnt_up = two_rise && FAST_IN_ONE;
                    cnt_dn = two_rise && !FAST_IN_ONE;
                end
                scid_pkg::SCID_DEC_UPDOWN: begin
                    cnt_up = two_rise && !one_rise;
                    cnt_dn = one_rise && !two_rise;
                end
                scid_pkg::SCID_DEC_QUAD: begin
                    cnt_up = quad_fwd;
                    cnt_dn = quad_rev;
                end
                default: begin
                    cnt_up = 1'b0;
                    cnt_dn = 1'b0;
                end
            endcase
        end
    end

    scid_scaler #(
        .W(16)
    ) u_scaler (
        .clk(CLK),
        .rst_n(RST_N),
        .step_up(cnt_up),
        .step_dn(cnt_dn),
        .ppt(ppt_q),
        .frac_q(POS_COUNT),
        .revs_q(POS_REVS)
    );

    // General-purpose view of the fast inputs when no decoder uses them
    wire gp_view = dec_sel == scid_pkg::SCID_DEC_GPIO;
    wire gp_one = gp_view && one_q;
    wire gp_two = gp_view && two_q;

    // Command path: converter code left-justified to 16 bits
    logic signed [15:0] analog16;
    assign analog16 = $signed({ANALOG_CMD, {(16 - ADC_W){1'b0}}});
    logic signed [32:0] cur_prod;
    logic signed [32:0] vel_prod;
    assign cur_prod = analog16 * $signed({1'b0, PEAK_CURRENT});
    assign vel_prod = analog16 * $signed({1'b0, top_q});

    logic signed [15:0] cur_target;
    logic signed [15:0] vel_target;
    assign cur_target = digital_src ? $signed(dtorq_q) : $signed(cur_prod[30:15]);
    assign vel_target = digital_src ? $signed(dspeed_q) : $signed(vel_prod[30:15]);

    // Slew limit: rise limit when speed magnitude grows, fall limit when it shrinks
    logic signed [16:0] vel_diff;
    logic [15:0] lim_up;
    logic [15:0] lim_dn;
    logic [16:0] sum_up;
    logic [16:0] sum_dn;
    assign vel_diff = {vel_target[15], vel_target} - {vel_q[15], vel_q};
    assign lim_up = vel_q[15] ? fall_q : rise_q;
    assign lim_dn = (vel_q[15] || vel_q == 16'sh0000) ? rise_q : fall_q;
    assign sum_up = {vel_q[15], vel_q} + {1'b0, lim_up};
    assign sum_dn = {vel_q[15], vel_q} - {1'b0, lim_dn};

    always_comb begin
        vel_d = vel_target;
        if (!MOTOR_POWER) begin
            vel_d = 16'sh0000;
        end else if (vel_diff > $signed({1'b0, lim_up})) begin
            vel_d = $signed(sum_up[15:0]);
        end else if (-vel_diff > $signed({1'b0, lim_dn})) begin
            vel_d = $signed(sum_dn[15:0]);
        end
    end

    // Read mux
    logic [31:0] status_w;
    assign status_w = {24'h000000, hw_en_q, gp_two, gp_one, overheat_q, LOADER_MODE,
        FOLDBACK, DRIVE_HEALTHY, MOTOR_POWER};
    wire [31:0] rd_mux = hit_ctrl ? {25'h0000000, ctrl_q}
        : hit_ppt ? {16'h0000, ppt_q}
        : hit_top ? {16'h0000, top_q}
        : hit_rise ? {16'h0000, rise_q}
        : hit_fall ? {16'h0000, fall_q}
        : hit_dtorq ? {16'h0000, dtorq_q}
        : hit_dspeed ? {16'h0000, dspeed_q}
        : hit_status ? status_w
        : hit_pos ? {POS_REVS, POS_COUNT}
        : hit_cmdout ? {VELOCITY_CMD, CURRENT_CMD}
        : 32'h00000000;

    // Register writes; loader mode ignores all software writes to settings
    wire wr_ok = wr && !LOADER_MODE;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ctrl_q <= scid_pkg::CTRL_RST;
            ppt_q <= scid_pkg::PPT_RST;
            top_q <= scid_pkg::TOP_RST;
            rise_q <= scid_pkg::RISE_RST;
            fall_q <= scid_pkg::FALL_RST;
            dtorq_q <= 16'h0000;
            dspeed_q <= 16'h0000;
        end else if (wr_ok) begin
            if (hit_ctrl) ctrl_q <= PWDATA[scid_pkg::CTRL_W-1:0];
            if (hit_ppt) ppt_q <= PWDATA[15:0];
            if (hit_top) top_q <= PWDATA[15:0];
            if (hit_rise) rise_q <= PWDATA[15:0];
            if (hit_fall) fall_q <= PWDATA[15:0];
            if (hit_dtorq) dtorq_q <= PWDATA[15:0];
            if (hit_dspeed) dspeed_q <= PWDATA[15:0];
        end
    end

    // Read data is captured in the setup cycle so PRDATA comes from a flip-flop;
    // a status bit that changes during the access cycle shows on the next read
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            prdata_q <= 32'h00000000;
        end else if (setup && !PWRITE) begin
            prdata_q <= rd_mux;
        end
    end

    // The enable history resets high: an enable already held at reset release
    // is a level, not an edge, so it cannot grant power on its own
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            st_q <= scid_pkg::SCID_ST_BOOT;
            one_q <= 1'b0;
            two_q <= 1'b0;
            ena_prev_q <= 1'b1;
            rstin_prev_q <= 1'b0;
            hw_en_q <= 1'b0;
            overheat_q <= 1'b0;
        end else begin
            st_q <= st_d;
            one_q <= FAST_IN_ONE;
            two_q <= FAST_IN_TWO;
            ena_prev_q <= ENABLE_IN;
            rstin_prev_q <= RESET_IN;
            hw_en_q <= hw_en_d;
            overheat_q <= overheat_d;
        end
    end

    // Outputs from flip-flops
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            MOTOR_POWER <= 1'b0;
            DRIVE_HEALTHY <= 1'b0;
            FOLDBACK <= 1'b0;
            vel_q <= 16'sh0000;
            CURRENT_CMD <= 16'h0000;
            VELOCITY_CMD <= 16'h0000;
        end else begin
            MOTOR_POWER <= power_d;
            DRIVE_HEALTHY <= MAIN_POWER_OK && !overheat_d && running;
            FOLDBACK <= FOLDBACK_ACTIVE;
            vel_q <= vel_d;
            CURRENT_CMD <= (power_d && !vel_mode) ? cur_target : 16'h0000;
            VELOCITY_CMD <= (power_d && vel_mode) ? vel_d : 16'h0000;
        end
    end

endmodule : scid_top

// ### scid_pkg.sv
// Shared constants and types for the servo command input decoder
package scid_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PPT = 8'h04;
    localparam logic [7:0] OFS_TOP = 8'h08;
    localparam logic [7:0] OFS_RISE = 8'h0C;
    localparam logic [7:0] OFS_FALL = 8'h10;
    localparam logic [7:0] OFS_DTORQ = 8'h14;
    localparam logic [7:0] OFS_DSPEED = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_POS = 8'h20;
    localparam logic [7:0] OFS_CMDOUT = 8'h24;

    // Control register fields
    localparam int CTRL_SEL_LO = 0;
    localparam int CTRL_SEL_HI = 1;
    localparam int CTRL_OR_COMBINE = 2;
    localparam int CTRL_SW_ENABLE = 3;
    localparam int CTRL_THERMAL_WATCH = 4;
    localparam int CTRL_VEL_MODE = 5;
    localparam int CTRL_DIGITAL_SRC = 6;
    localparam int CTRL_W = 7;

    // Status register fields
    localparam int STAT_POWER = 0;
    localparam int STAT_HEALTHY = 1;
    localparam int STAT_FOLDBACK = 2;
    localparam int STAT_LOADER = 3;
    localparam int STAT_OVERHEAT = 4;
    localparam int STAT_GP_ONE = 5;
    localparam int STAT_GP_TWO = 6;
    localparam int STAT_HW_ENABLE = 7;

    // Values after reset; velocity mode, step/direction decoding
    localparam logic [6:0] CTRL_RST = 7'h20;
    localparam logic [15:0] PPT_RST = 16'h03E8;
    localparam logic [15:0] TOP_RST = 16'h1000;
    localparam logic [15:0] RISE_RST = 16'h0010;
    localparam logic [15:0] FALL_RST = 16'h0010;

    typedef enum logic [1:0] {
        SCID_DEC_STEPDIR = 2'h0,
        SCID_DEC_UPDOWN = 2'h1,
        SCID_DEC_QUAD = 2'h2,
        SCID_DEC_GPIO = 2'h3
    } scid_dec_t;

    typedef enum logic [3:0] {
        SCID_ST_BOOT = 4'h1,
        SCID_ST_RUN = 4'h2,
        SCID_ST_LDLOW = 4'h4,
        SCID_ST_LDHIGH = 4'h8
    } scid_state_t;

endpackage : scid_pkg

// ### scid_scaler.sv
// Position accumulator: counts within one turn and whole turns
`timescale 1ns/100ps
module scid_scaler #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic step_up,
    input wire logic step_dn,
    input wire logic [W-1:0] ppt,
    output logic [W-1:0] frac_q,
    output logic [W-1:0] revs_q
);
    logic [W-1:0] ppt_eff;
    logic [W-1:0] top;
    logic [W-1:0] frac_d;
    logic [W-1:0] revs_d;

    // A zero setting would never wrap; treat it as one count per turn
    assign ppt_eff = (ppt == '0) ? W'(1) : ppt;
    assign top = ppt_eff - W'(1);

    always_comb begin
        frac_d = frac_q;
        revs_d = revs_q;
        if (step_up && !step_dn) begin
            if (frac_q >= top) begin
                frac_d = '0;
                revs_d = revs_q + W'(1);
            end else begin
                frac_d = frac_q + W'(1);
            end
        end else if (step_dn && !step_up) begin
            if (frac_q == '0) begin
                frac_d = top;
                revs_d = revs_q - W'(1);
            end else begin
                frac_d = frac_q - W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            frac_q <= '0;
            revs_q <= '0;
        end else begin
            frac_q <= frac_d;
            revs_q <= revs_d;
        end
    end

endmodule : scid_scaler

// ### scid_assertions.sv
// Port-level assertions for the servo command input decoder
`timescale 1ns/100ps
module scid_assertions (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic FAST_IN_ONE,
    input wire logic FAST_IN_TWO,
    input wire logic RESET_IN,
    input wire logic MAIN_POWER_OK,
    input wire logic FOLDBACK_ACTIVE,
    input wire logic MOTOR_POWER,
    input wire logic DRIVE_HEALTHY,
    input wire logic FOLDBACK,
    input wire logic LOADER_MODE,
    input wire logic [15:0] POS_COUNT,
    input wire logic [15:0] POS_REVS,
    input wire logic [15:0] CURRENT_CMD,
    input wire logic [15:0] VELOCITY_CMD
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    AST_FOLDBACK_FOLLOWS: assert property (FOLDBACK_ACTIVE |=> FOLDBACK)
        else $error("foldback output missed an active reduction");
    AST_HEALTHY_NEEDS_MAIN: assert property (!MAIN_POWER_OK |=> !DRIVE_HEALTHY)
        else $error("healthy shown without main power");
    // Power register takes the reset input directly, so one edge is enough
    AST_RESET_CUTS_POWER: assert property (RESET_IN |=> !MOTOR_POWER)
        else $error("motor power kept while reset input active");
    AST_LOADER_NO_POWER: assert property (LOADER_MODE |-> !MOTOR_POWER)
        else $error("motor power in loader mode");
    AST_LOADER_UNHEALTHY: assert property (LOADER_MODE |-> !DRIVE_HEALTHY)
        else $error("healthy shown in loader mode");
    AST_REVS_AT_WRAP: assert property ($changed(POS_REVS) |->
        (POS_COUNT == 16'h0) || ($past(POS_COUNT) == 16'h0))
        else $error("turn count moved away from a wrap of the in-turn count");
    AST_POS_HOLDS: assert property (($stable(FAST_IN_ONE) && $stable(FAST_IN_TWO)) [*3]
        |=> $stable(POS_COUNT) && $stable(POS_REVS))
        else $error("position moved without input activity");
    AST_CMD_ZERO_UNPOWERED: assert property (!MOTOR_POWER [*2] |->
        CURRENT_CMD == 16'h0 && VELOCITY_CMD == 16'h0)
        else $error("command nonzero without motor power");
endmodule : scid_assertions

bind scid_top scid_assertions u_chk (.CLK(CLK), .RST_N(RST_N), .FAST_IN_ONE(FAST_IN_ONE),
    .FAST_IN_TWO(FAST_IN_TWO), .RESET_IN(RESET_IN), .MAIN_POWER_OK(MAIN_POWER_OK),
    .FOLDBACK_ACTIVE(FOLDBACK_ACTIVE), .MOTOR_POWER(MOTOR_POWER),
    .DRIVE_HEALTHY(DRIVE_HEALTHY), .FOLDBACK(FOLDBACK), .LOADER_MODE(LOADER_MODE),
    .POS_COUNT(POS_COUNT), .POS_REVS(POS_REVS), .CURRENT_CMD(CURRENT_CMD),
    .VELOCITY_CMD(VELOCITY_CMD));

// ### scid_motion_ctrl.sv
// Motion controller model driving the two fast command inputs
`timescale 1ns/100ps
module scid_motion_ctrl (
    input wire logic clk,
    output logic fast_one,
    output logic fast_two
);
    // Quadrature codes {A,B} by phase index, index rising for forward motion
    localparam logic [7:0] QUAD_SEQ = 8'h78;
    logic [1:0] phase_q;

    initial begin
        fast_one = 1'b0;
        fast_two = 1'b0;
        phase_q = 2'h0;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask : hold

    task automatic levels(input logic a, input logic b);
        fast_one <= a;
        fast_two <= b;
        hold(1);
    endtask : levels

    // Only call while the decoder is parked, or a quadrature jump may count
    task automatic park();
        phase_q = 2'h0;
        levels(1'b0, 1'b0);
    endtask : park

    // gap sets how long each level is held: 1 is the fastest legal rate
    task automatic move(input logic [1:0] mode, input logic up, input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            case (mode)
                2'h0: begin
                    fast_one <= up;
                    hold(gap);
                    fast_two <= 1'b1;
                    hold(gap);
                    fast_two <= 1'b0;
                    hold(gap);
                end
                2'h1: begin
                    if (up) begin
                        fast_two <= 1'b1;
                    end else begin
                        fast_one <= 1'b1;
                    end
                    hold(gap);
                    fast_one <= 1'b0;
                    fast_two <= 1'b0;
                    hold(gap);
                end
                default: begin
                    phase_q = up ? phase_q + 2'h1 : phase_q - 2'h1;
                    {fast_one, fast_two} <= QUAD_SEQ[{phase_q, 1'b0} +: 2];
                    hold(gap);
                end
            endcase
        end
    endtask : move
endmodule : scid_motion_ctrl

// ### tb_servo_command_input_decoder.sv
// Self-checking bench for the servo command input decoder
`timescale 1ns/100ps
module tb_servo_command_input_decoder;
    logic CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, FAST_IN_ONE, FAST_IN_TWO;
    logic ENABLE_IN, RESET_IN, OVERHEAT_IN, MAIN_POWER_OK, FOLDBACK_ACTIVE;
    logic MOTOR_POWER, DRIVE_HEALTHY, FOLDBACK, LOADER_MODE;
    logic [7:0] PADDR;
    logic [31:0] PWDATA, PRDATA, seed, r;
    logic [13:0] ANALOG_CMD;
    logic [15:0] POS_COUNT, POS_REVS, CURRENT_CMD, VELOCITY_CMD, vel_last;
    logic [33:0] q[$];
    logic [15:0] vq[$];
    logic [33:0] e;
    int errors, compares, pos;

    scid_top uut (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .FAST_IN_ONE(FAST_IN_ONE), .FAST_IN_TWO(FAST_IN_TWO), .ENABLE_IN(ENABLE_IN),
        .RESET_IN(RESET_IN), .OVERHEAT_IN(OVERHEAT_IN), .MAIN_POWER_OK(MAIN_POWER_OK),
        .FOLDBACK_ACTIVE(FOLDBACK_ACTIVE), .ANALOG_CMD(ANALOG_CMD), .MOTOR_POWER(MOTOR_POWER),
        .DRIVE_HEALTHY(DRIVE_HEALTHY), .FOLDBACK(FOLDBACK), .LOADER_MODE(LOADER_MODE),
        .POS_COUNT(POS_COUNT), .POS_REVS(POS_REVS), .CURRENT_CMD(CURRENT_CMD),
        .VELOCITY_CMD(VELOCITY_CMD));
    scid_motion_ctrl mc (.clk(CLK), .fast_one(FAST_IN_ONE), .fast_two(FAST_IN_TWO));

    initial begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    // Position word for three counts a turn; floor division keeps negatives right
    function automatic logic [31:0] posw(input int p);
        int rv;
        int c;
        rv = p / 3;
        c = p % 3;
        if (c < 0) begin
            c += 3;
            rv -= 1;
        end
        return {rv[15:0], c[15:0]};
    endfunction : posw

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results

    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
    endtask : cyc

    // On a read, d is the expected data and goes out on PWDATA unused
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic ee);
        q.push_back({~wr, ee, d});
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLK);
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 1'b0);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b0, a, d, 1'b0);
    endtask : rd

    always @(posedge CLK) begin
        if (PSEL && PENABLE && PREADY) begin
            e = q.pop_front();
            check({31'h0, PSLVERR}, {31'h0, e[32]});
            if (e[33]) begin
                check(PRDATA, e[31:0]);
            end
        end
        if (RST_N === 1'b1 && VELOCITY_CMD !== vel_last) begin
            vel_last = VELOCITY_CMD;
            if (vq.size() > 0) begin
                check({16'h0, VELOCITY_CMD}, {16'h0, vq.pop_front()});
            end else begin
                check({16'h0, VELOCITY_CMD}, 32'hFFFF_FFFF);
            end
        end
    end

    initial begin
        cyc(20000);
        check(32'h1, 32'h0);
        results();
    end

    initial begin
        {RST_N, PSEL, PENABLE, PWRITE, ENABLE_IN, RESET_IN, OVERHEAT_IN, FOLDBACK_ACTIVE} = 8'h0;
        MAIN_POWER_OK = 1'b1;
        PADDR = 8'h0;
        PWDATA = 32'h0;
        ANALOG_CMD = 14'h0;
        vel_last = 16'h0;
        seed = 32'h0000_01A9;
        cyc(16);
        RST_N <= 1'b1;
        cyc(2);
        rd(scid_pkg::OFS_CTRL, 32'h20);
        rd(scid_pkg::OFS_PPT, 32'h3E8);
        xfer(1'b1, scid_pkg::OFS_STATUS, 32'h0, 1'b1);
        xfer(1'b0, 8'h40, 32'h0, 1'b1);
        rd(scid_pkg::OFS_STATUS, 32'h02);
        $display("registers test done");
        wr(scid_pkg::OFS_PPT, 32'h3);
        pos = 0;
        for (int m = 0; m < 3; m++) begin
            wr(scid_pkg::OFS_CTRL, 32'h23);
            mc.park();
            wr(scid_pkg::OFS_CTRL, 32'h20 | m);
            mc.move(m[1:0], 1'b1, 5, 1);
            mc.move(m[1:0], 1'b0, 7, 2);
            pos -= 2;
            cyc(3);
            rd(scid_pkg::OFS_POS, posw(pos));
        end
        wr(scid_pkg::OFS_CTRL, 32'h23);
        mc.levels(1'b1, 1'b0);
        cyc(2);
        rd(scid_pkg::OFS_STATUS, 32'h22);
        mc.levels(1'b0, 1'b1);
        cyc(2);
        rd(scid_pkg::OFS_STATUS, 32'h42);
        rd(scid_pkg::OFS_POS, posw(pos));
        mc.park();
        $display("decoder test done");
        ENABLE_IN <= 1'b1;
        cyc(3);
        rd(scid_pkg::OFS_STATUS, 32'h82);
        wr(scid_pkg::OFS_CTRL, 32'h2B);
        cyc(2);
        rd(scid_pkg::OFS_STATUS, 32'h83);
        RESET_IN <= 1'b1;
        cyc(2);
        rd(scid_pkg::OFS_STATUS, 32'h02);
        RESET_IN <= 1'b0;
        cyc(3);
        rd(scid_pkg::OFS_STATUS, 32'h83);
        wr(scid_pkg::OFS_CTRL, 32'h3B);
        OVERHEAT_IN <= 1'b1;
        cyc(3);
        rd(scid_pkg::OFS_STATUS, 32'h10);
        OVERHEAT_IN <= 1'b0;
        cyc(3);
        rd(scid_pkg::OFS_STATUS, 32'h10);
        RESET_IN <= 1'b1;
        cyc(2);
        RESET_IN <= 1'b0;
        cyc(3);
        rd(scid_pkg::OFS_STATUS, 32'h83);
        wr(scid_pkg::OFS_CTRL, 32'h2B);
        OVERHEAT_IN <= 1'b1;
        FOLDBACK_ACTIVE <= 1'b1;
        cyc(3);
        rd(scid_pkg::OFS_STATUS, 32'h87);
        {OVERHEAT_IN, FOLDBACK_ACTIVE, MAIN_POWER_OK} <= 3'h0;
        cyc(2);
        rd(scid_pkg::OFS_STATUS, 32'h81);
        MAIN_POWER_OK <= 1'b1;
        ENABLE_IN <= 1'b0;
        cyc(3);
        rd(scid_pkg::OFS_STATUS, 32'h02);
        wr(scid_pkg::OFS_CTRL, 32'h2F);
        cyc(2);
        rd(scid_pkg::OFS_STATUS, 32'h03);
        $display("enable test done");
        wr(scid_pkg::OFS_CTRL, 32'h4F);
        repeat (4) begin
            r = xs();
            wr(scid_pkg::OFS_DTORQ, r);
            cyc(2);
            rd(scid_pkg::OFS_CMDOUT, {16'h0, r[15:0]});
        end
        wr(scid_pkg::OFS_CTRL, 32'h0F);
        ANALOG_CMD <= 14'h1FFF;
        cyc(3);
        rd(scid_pkg::OFS_CMDOUT, 32'h3FFE);
        ANALOG_CMD <= 14'h2000;
        cyc(3);
        rd(scid_pkg::OFS_CMDOUT, 32'hC000);
        ANALOG_CMD <= 14'h0;
        wr(scid_pkg::OFS_RISE, 32'h4);
        wr(scid_pkg::OFS_FALL, 32'h8);
        wr(scid_pkg::OFS_DSPEED, 32'h20);
        for (int i = 1; i <= 8; i++) vq.push_back(16'(4 * i));
        wr(scid_pkg::OFS_CTRL, 32'h6F);
        cyc(12);
        for (int i = 1; i <= 8; i++) vq.push_back(i < 5 ? 16'(32 - 8 * i) : 16'(16 - 4 * i));
        wr(scid_pkg::OFS_DSPEED, 32'hFFF0);
        cyc(12);
        wr(scid_pkg::OFS_FALL, 32'h7FFF);
        wr(scid_pkg::OFS_RISE, 32'h7FFF);
        ANALOG_CMD <= 14'h1FFF;
        vq.push_back(16'h0FFF);
        wr(scid_pkg::OFS_CTRL, 32'h2F);
        cyc(3);
        vq.push_back(16'h0);
        wr(scid_pkg::OFS_CTRL, 32'h23);
        cyc(3);
        check(32'(vq.size()), 32'h0);
        $display("command test done");
        RESET_IN <= 1'b1;
        RST_N <= 1'b0;
        cyc(16);
        RST_N <= 1'b1;
        cyc(3);
        rd(scid_pkg::OFS_STATUS, 32'h08);
        wr(scid_pkg::OFS_CTRL, 32'h2F);
        rd(scid_pkg::OFS_CTRL, 32'h20);
        RESET_IN <= 1'b0;
        cyc(2);
        RESET_IN <= 1'b1;
        cyc(2);
        RESET_IN <= 1'b0;
        cyc(3);
        rd(scid_pkg::OFS_STATUS, 32'h02);
        $display("loader test done");
        results();
    end
endmodule : tb_servo_command_input_decoder
